// ===== include/mof_pkg.sv
/*
  Shared definitions for the measurement output formatter: command and sample
  carriers, format codes, signal selector ranges, scaling and pacing constants.
  Assumes a 50 MHz system clock and a 75 Hz measurement cycle strobe.
*/
package mof_pkg;

  // ****************************************
  // Commands and carriers
  // ****************************************
  typedef enum logic [2:0] {
    OP_NONE, OP_FORMAT_SELECT, OP_FORMAT_QUERY, OP_RATE_DIVIDER,
    OP_VALUE_REQUEST, OP_AUX_VALUE_QUERY, OP_OUTPUT_HALT
  } mof_op_t;

  typedef struct packed {
    mof_op_t op;
    logic [15:0] p1;
    logic [15:0] p2;
    logic p2_given;
    logic [15:0] p3;
  } mof_cmd_t;

  typedef struct packed {
    logic signed [31:0] eng;
    logic signed [23:0] raw;
    logic [7:0] status;
  } mof_sample_t;

  typedef struct packed {
    logic signed [31:0] volt;
    logic signed [31:0] res;
    logic signed [31:0] temp;
    logic signed [31:0] cur;
    logic signed [31:0] tres;
    logic res_open;
    logic res_low;
    logic exc_limit;
  } mof_aux_t;

  // ****************************************
  // Format codes and characters
  // ****************************************
  localparam logic [2:0] FMT_ASCII_FULL = 3'h0;
  localparam logic [2:0] FMT_BIN4_FIRST = 3'h2;
  localparam logic [2:0] FMT_BIN2_FIRST = 3'h4;
  localparam logic [2:0] FMT_MAX = 3'h5;
  localparam logic [2:0] FMT_RESET = 3'h0;
  localparam logic [7:0] CH_ZERO = 8'h30;
  localparam logic [7:0] CH_ERROR = 8'h3F;
  localparam logic [7:0] CH_HASH = 8'h23;
  localparam logic [7:0] CH_DOT = 8'h2E;
  localparam logic [7:0] CH_MINUS = 8'h2D;
  localparam logic [7:0] CH_ONE = 8'h31;

  // ****************************************
  // Signal selector ranges
  // ****************************************
  localparam logic [15:0] SIG_FIRST = 16'h0001;
  localparam logic [15:0] SIG_PEAK_A = 16'h0003;
  localparam logic [15:0] SIG_PEAK_B = 16'h0004;
  localparam logic [15:0] SIG_LIM_FIRST = 16'h0005;
  localparam logic [15:0] SIG_LIM_LAST = 16'h000C;
  localparam logic [15:0] SIG_DYN_FIRST = 16'h000D;
  localparam logic [15:0] SIG_DYN_LAST = 16'h000F;
  localparam logic [15:0] SIG_ABS = 16'h0010;
  localparam logic [15:0] SIG_MVV_FIRST = 16'h0020;
  localparam logic [15:0] SIG_PEAK_MVV_FIRST = 16'h0023;
  localparam logic [15:0] SIG_PEAK_MVV_LAST = 16'h0028;
  localparam logic [15:0] SIG_PEAK_U2_FIRST = 16'h002C;
  localparam logic [15:0] SIG_LAST = 16'h0031;

  // ****************************************
  // Scaling, ranges and timing
  // ****************************************
  localparam logic [23:0] FULL_SCALE_4B = 24'h75_3000;
  localparam logic [15:0] FULL_SCALE_2B = 16'h7530;
  localparam int BIN2_SHIFT = 8;
  localparam logic [15:0] COUNT_DEFAULT = 16'h0001;
  localparam logic [15:0] RATE_DIV_RESET = 16'h0001;
  localparam logic [15:0] INTERVAL_MIN = 16'h0001;
  localparam logic [15:0] INTERVAL_MAX = 16'h0258;
  localparam logic [15:0] AUX_CODE_MAX = 16'h0005;
  localparam int CLK_PERIOD_NS = 20;
  localparam int INTERVAL_UNIT_NS = 100_000_000;
  localparam int TENTH_CYC = INTERVAL_UNIT_NS / CLK_PERIOD_NS;
  localparam logic signed [31:0] AUX_OPEN_OHM = 32'sh000F_423F;
  localparam logic signed [31:0] AUX_OPEN_DEG = 32'sh0000_4E20;
  localparam logic signed [31:0] AUX_LOW_DEG = -32'sh0000_2710;
  localparam logic signed [31:0] AUX_LIMIT_MA = 32'sh0000_270F;
  localparam logic signed [31:0] AUX_RES_MAX = 32'sh0001_869F;
  localparam logic [2:0] AUX_DEC_VOLT = 3'h3;
  localparam logic [2:0] AUX_DEC_TENTH = 3'h1;
  localparam logic [2:0] AUX_DEC_HUNDREDTH = 3'h2;

endpackage

// ===== logic/mof_formatter.sv
/*
  Measurement output formatter: takes decoded host commands, keeps the output
  format and rate divider, and streams value, auxiliary and acknowledge bytes.
  Assumes an upstream parser delivering one decoded command per handshake, a
  measurement chain presenting the selected signal, and a byte link that can stall.
*/
`timescale 1ns/1ns

// Summary of operation
// - Format codes 0..5 select ASCII or binary.
// - Four-byte binary: value then status, ordered.
// - Four-byte full scale equals 7680000 counts.
// - Two-byte binary full scale equals 30000 counts.
// - Temperature counts 1/2560 or 1/10 degree.
// - Format select answers 0 or question mark.
// - One format setting serves every channel.
// - ASCII scaled units, binary raw converter units.
// - Format query returns stored format code.
// - Dynamic binary signals paced by 75 Hz/divider.
// - Value request decodes documented signal selectors.
// - Count 0 continuous, else 1..65535, default 1.
// - Non-dynamic binary values spaced by 0.1..60 s interval.
// - Responses use current format, separators, channel.
// - Sign reversal skips peak and limit signals.
// - Full ASCII: value, channel, status, separated.
// - Binary header: hash, length digit, count; #0 alone when continuous.
// - Aux query codes 1..5 return fixed-decimal ASCII.
// - Aux values refresh slowly, queries read store.
// - Open input 9999.99 ohm/200 deg, low -100.
// - Limiting: 999.9 mA, 0 ohm; clamp 9999.9.
// - Halt ends counted or continuous output.
// - Parameter and block separators inserted.
module mof_formatter
  import mof_pkg::*;
#(
  parameter int unsigned TENTH_CYCLES = TENTH_CYC
)
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic cmd_valid,
  input wire mof_cmd_t cmd,
  output logic cmd_ready,
  input wire logic meas_tick,
  input wire mof_sample_t sample,
  output logic [5:0] sig_select,
  input wire logic [2:0] eng_decimals,
  input wire logic [3:0] channel_select_cmd,
  input wire logic sign_reversal_input,
  input wire logic aux_update,
  input wire mof_aux_t aux,
  input wire logic [7:0] param_sep,
  input wire logic [7:0] block_sep,
  output logic out_valid,
  output logic [7:0] out_data,
  input wire logic out_ready,
  output logic [2:0] fmt_code,
  output logic [15:0] rate_div,
  output logic busy
);

  // ****************************************
  // State and storage
  // ****************************************
  typedef enum logic [2:0] {
    ST_IDLE = 3'b000, ST_LOAD = 3'b001, ST_CONV = 3'b011, ST_SEND = 3'b010, ST_WAIT = 3'b110
  } mof_state_t;
  typedef enum logic [1:0] {JOB_REPLY, JOB_HEADER, JOB_VALUE} mof_job_t;

  mof_state_t state;
  mof_job_t job;
  logic [15:0] remain;
  logic cont;
  logic ascii_job;
  logic [15:0] interval;
  logic [31:0] pace;
  logic [31:0] pre_vec;
  logic [2:0] pre_n;
  logic [63:0] tail_vec;
  logic [3:0] tail_n;
  logic [7:0] num [0:11];
  logic [3:0] num_n;
  logic neg;
  logic [31:0] conv_v;
  logic [3:0] conv_k;
  logic [2:0] conv_dec;
  logic [4:0] seq;
  logic signed [31:0] aux_num [0:4];
  logic [2:0] aux_dec [0:4];

  // Appends one character to a left-justified byte string.
  function automatic logic [63:0] put(input logic [63:0] v, input logic [3:0] n, input logic [7:0] c);
    put = v | ({c, 56'h0} >> (8 * n));
  endfunction

  // Number of decimal digits of a byte count, at least one.
  function automatic logic [7:0] ndig(input logic [17:0] v);
    ndig = (v < 18'd10) ? 8'd1 : (v < 18'd100) ? 8'd2 : (v < 18'd1000) ? 8'd3 :
           (v < 18'd10000) ? 8'd4 : (v < 18'd100000) ? 8'd5 : 8'd6;
  endfunction

  // ****************************************
  // Command decode and validation
  // ****************************************
  wire take = cmd_valid && cmd_ready;
  wire halt_now = take && (cmd.op == OP_OUTPUT_HALT);
  wire fmt_ok = cmd.p1 <= {13'h0, FMT_MAX};
  wire div_ok = cmd.p1 != 16'h0;
  wire sig_ok = (cmd.p1 >= SIG_FIRST && cmd.p1 <= SIG_ABS) ||
                (cmd.p1 >= SIG_MVV_FIRST && cmd.p1 <= SIG_LAST);
  wire ivl_ok = (cmd.p3 == 16'h0) || (cmd.p3 >= INTERVAL_MIN && cmd.p3 <= INTERVAL_MAX);
  wire aux_ok = cmd.p1 >= SIG_FIRST && cmd.p1 <= AUX_CODE_MAX;
  wire [15:0] req_count = cmd.p2_given ? cmd.p2 : COUNT_DEFAULT;

  // Halt is the only command taken while a stream waits between values.
  assign cmd_ready = (state == ST_IDLE) || (state == ST_WAIT && cmd.op == OP_OUTPUT_HALT);
  assign busy = state != ST_IDLE;

  // ****************************************
  // Value formatting
  // ****************************************
  wire [15:0] sig16 = {10'h0, sig_select};
  wire sel_peak = sig16 == SIG_PEAK_A || sig16 == SIG_PEAK_B ||
                  (sig16 >= SIG_PEAK_MVV_FIRST && sig16 <= SIG_PEAK_MVV_LAST) ||
                  (sig16 >= SIG_PEAK_U2_FIRST && sig16 <= SIG_LAST);
  wire sel_limit = sig16 >= SIG_LIM_FIRST && sig16 <= SIG_LIM_LAST;
  wire sel_dyn = sig16 >= SIG_DYN_FIRST && sig16 <= SIG_DYN_LAST;
  wire invert = sign_reversal_input && !sel_peak && !sel_limit;
  wire signed [31:0] eng_v = invert ? -sample.eng : sample.eng;
  wire signed [23:0] raw_v = invert ? -sample.raw : sample.raw;
  // Raw counts reach the host unscaled; 2-byte is the 4-byte count over 256.
  wire [15:0] bin16 = raw_v[23:BIN2_SHIFT];
  wire fmt_binary = fmt_code >= FMT_BIN4_FIRST;
  wire fmt_four = fmt_code < FMT_BIN2_FIRST;
  wire [31:0] bin_msb = fmt_four ? {raw_v, sample.status} : {bin16, 16'h0};
  wire [31:0] bin_lsb = fmt_four ? {sample.status, raw_v[7:0], raw_v[15:8], raw_v[23:16]} :
                                   {bin16[7:0], bin16[15:8], 16'h0};
  wire [2:0] bin_n = fmt_four ? 3'h4 : 3'h2;
  wire [17:0] byte_count = fmt_four ? {req_count, 2'b00} : {1'b0, req_count, 1'b0};
  wire [7:0] len_char = CH_ZERO + ndig(byte_count);
  wire [7:0] st_h = sample.status / 8'd100;
  wire [7:0] st_t = (sample.status / 8'd10) % 8'd10;
  wire [7:0] st_o = sample.status % 8'd10;

  // Tail of an ASCII value: separators, channel and status as the format asks.
  logic [63:0] a_tail;
  logic [3:0] a_n;
  always_comb
  begin
    a_tail = 64'h0;
    a_n = 4'h0;
    if (fmt_code == FMT_ASCII_FULL)
    begin
      a_tail = put(a_tail, a_n, param_sep);
      a_n = a_n + 4'h1;
      if (channel_select_cmd >= 4'd10)
      begin
        a_tail = put(a_tail, a_n, CH_ONE);
        a_n = a_n + 4'h1;
      end
      a_tail = put(a_tail, a_n, CH_ZERO + {4'h0, channel_select_cmd % 4'd10});
      a_n = a_n + 4'h1;
      a_tail = put(a_tail, a_n, param_sep);
      a_n = a_n + 4'h1;
      if (st_h != 8'h0)
      begin
        a_tail = put(a_tail, a_n, CH_ZERO + st_h);
        a_n = a_n + 4'h1;
      end
      if (st_h != 8'h0 || st_t != 8'h0)
      begin
        a_tail = put(a_tail, a_n, CH_ZERO + st_t);
        a_n = a_n + 4'h1;
      end
      a_tail = put(a_tail, a_n, CH_ZERO + st_o);
      a_n = a_n + 4'h1;
    end
    a_tail = put(a_tail, a_n, block_sep);
    a_n = a_n + 4'h1;
  end

  // ****************************************
  // Byte emitter selection
  // ****************************************
  wire [4:0] nlen = {1'b0, num_n} + {4'h0, neg};
  wire [4:0] total = {2'b00, pre_n} + nlen + {1'b0, tail_n};
  wire [4:0] j_num = seq - {2'b00, pre_n};
  wire [4:0] j_tail = j_num - nlen;
  wire [3:0] num_pos = 4'(num_n - 4'h1 - 4'(j_num - {4'h0, neg}));
  wire [7:0] cur_char = (seq < {2'b00, pre_n}) ? pre_vec[31 - 8 * seq -: 8] :
                        (j_num < nlen) ? ((neg && j_num == 5'h0) ? CH_MINUS : num[num_pos]) :
                        tail_vec[63 - 8 * j_tail -: 8];
  wire last_byte = seq == total - 5'h1;
  wire [31:0] conv_q = conv_v / 32'd10;
  wire [7:0] conv_d = 8'(conv_v % 32'd10);
  wire conv_done = conv_q == 32'h0 && (conv_dec == 3'h0 || conv_k > {1'b0, conv_dec});
  wire pace_step = (!ascii_job && interval != 16'h0 && !sel_dyn) || meas_tick;
  wire [31:0] pace_load = ascii_job ? 32'h1 : sel_dyn ? {16'h0, rate_div} :
                          (interval != 16'h0) ? 32'(interval * TENTH_CYCLES) : 32'h1;

  // ****************************************
  // Auxiliary value store
  // ****************************************
  // Refreshed only on the slow strobe, so repeated queries read one value.
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      for (int i = 0; i < 5; i++)
      begin
        aux_num[i] <= 32'sh0;
        aux_dec[i] <= 3'h0;
      end
    end
    else if (aux_update)
    begin
      aux_num[0] <= aux.volt;
      aux_dec[0] <= AUX_DEC_VOLT;
      aux_num[1] <= aux.res_open ? AUX_OPEN_OHM : aux.res;
      aux_dec[1] <= aux.res_open ? AUX_DEC_HUNDREDTH : AUX_DEC_TENTH;
      aux_num[2] <= aux.res_open ? AUX_OPEN_DEG : aux.res_low ? AUX_LOW_DEG : aux.temp;
      aux_dec[2] <= AUX_DEC_HUNDREDTH;
      aux_num[3] <= aux.exc_limit ? AUX_LIMIT_MA : aux.cur;
      aux_dec[3] <= AUX_DEC_TENTH;
      aux_num[4] <= aux.exc_limit ? 32'sh0 : (aux.tres > AUX_RES_MAX) ? AUX_RES_MAX : aux.tres;
      aux_dec[4] <= AUX_DEC_TENTH;
    end
  end

  // ****************************************
  // Control sequencer
  // ****************************************
  // One process owns the message registers so every byte of a reply is coherent.
  always_ff @(posedge sys_clk or posedge rst)
  begin
    if (rst)
    begin
      state <= ST_IDLE;
      job <= JOB_REPLY;
      fmt_code <= FMT_RESET;
      rate_div <= RATE_DIV_RESET;
      sig_select <= 6'h0;
      remain <= 16'h0;
      cont <= 1'b0;
      ascii_job <= 1'b0;
      interval <= 16'h0;
      pace <= 32'h0;
      pre_vec <= 32'h0;
      pre_n <= 3'h0;
      tail_vec <= 64'h0;
      tail_n <= 4'h0;
      num_n <= 4'h0;
      neg <= 1'b0;
      conv_v <= 32'h0;
      conv_k <= 4'h0;
      conv_dec <= 3'h0;
      seq <= 5'h0;
      out_valid <= 1'b0;
      out_data <= 8'h0;
      for (int i = 0; i < 12; i++)
      begin
        num[i] <= 8'h0;
      end
    end
    else
    begin
      case (state)
        ST_IDLE:
        begin
          seq <= 5'h0;
          num_n <= 4'h0;
          neg <= 1'b0;
          tail_n <= 4'h0;
          conv_k <= 4'h0;
          job <= JOB_REPLY;
          pre_n <= 3'h1;
          pre_vec <= {CH_ERROR, 24'h0};
          if (take)
          begin
            state <= ST_SEND;
            case (cmd.op)
              OP_FORMAT_SELECT:
                if (fmt_ok)
                begin
                  fmt_code <= cmd.p1[2:0];
                  pre_vec <= {CH_ZERO, 24'h0};
                end
              OP_RATE_DIVIDER:
                if (div_ok)
                begin
                  rate_div <= cmd.p1;
                  pre_vec <= {CH_ZERO, 24'h0};
                end
              OP_FORMAT_QUERY:
              begin
                pre_vec <= {CH_ZERO + {5'h0, fmt_code}, 24'h0};
                pre_n <= 3'h1;
              end
              OP_AUX_VALUE_QUERY:
                if (aux_ok)
                begin
                  pre_n <= 3'h0;
                  neg <= aux_num[cmd.p1[2:0] - 3'h1] < 0;
                  conv_v <= (aux_num[cmd.p1[2:0] - 3'h1] < 0) ? 32'(-aux_num[cmd.p1[2:0] - 3'h1]) :
                            32'(aux_num[cmd.p1[2:0] - 3'h1]);
                  conv_dec <= aux_dec[cmd.p1[2:0] - 3'h1];
                  state <= ST_CONV;
                end
              OP_VALUE_REQUEST:
                if (sig_ok && ivl_ok)
                begin
                  sig_select <= cmd.p1[5:0];
                  remain <= req_count;
                  cont <= req_count == 16'h0;
                  interval <= cmd.p3;
                  ascii_job <= !fmt_binary;
                  if (fmt_binary)
                  begin
                    job <= JOB_HEADER;
                    pre_n <= 3'h2;
                    pre_vec <= {CH_HASH, (req_count == 16'h0) ? CH_ZERO : len_char, 16'h0};
                    conv_v <= {14'h0, byte_count};
                    conv_dec <= 3'h0;
                    if (req_count != 16'h0)
                      state <= ST_CONV;
                  end
                  else
                    state <= ST_LOAD;
                end
              OP_OUTPUT_HALT:
                state <= ST_IDLE;
              default:
                pre_n <= 3'h1;
            endcase
          end
        end
        ST_LOAD:
        begin
          seq <= 5'h0;
          job <= JOB_VALUE;
          conv_k <= 4'h0;
          num_n <= 4'h0;
          if (fmt_binary)
          begin
            pre_vec <= fmt_code[0] ? bin_lsb : bin_msb;
            pre_n <= bin_n;
            neg <= 1'b0;
            tail_n <= 4'h0;
            state <= ST_SEND;
          end
          else
          begin
            pre_n <= 3'h0;
            neg <= eng_v < 0;
            conv_v <= (eng_v < 0) ? 32'(-eng_v) : 32'(eng_v);
            conv_dec <= eng_decimals;
            tail_vec <= a_tail;
            tail_n <= a_n;
            state <= ST_CONV;
          end
        end
        ST_CONV:
        begin
          conv_k <= conv_k + 4'h1;
          if (conv_dec != 3'h0 && conv_k == {1'b0, conv_dec})
            num[conv_k] <= CH_DOT;
          else
          begin
            num[conv_k] <= CH_ZERO + conv_d;
            conv_v <= conv_q;
            if (conv_done)
            begin
              num_n <= conv_k + 4'h1;
              seq <= 5'h0;
              state <= ST_SEND;
            end
          end
        end
        ST_SEND:
          if (!out_valid)
          begin
            out_data <= cur_char;
            out_valid <= 1'b1;
          end
          else if (out_ready)
          begin
            out_valid <= 1'b0;
            seq <= seq + 5'h1;
            if (last_byte)
            begin
              if (job == JOB_REPLY)
                state <= ST_IDLE;
              else if (job == JOB_HEADER)
                state <= ST_LOAD;
              else if (!cont && remain == 16'h1)
                state <= ST_IDLE;
              else
              begin
                if (!cont)
                  remain <= remain - 16'h1;
                pace <= pace_load;
                state <= ST_WAIT;
              end
            end
          end
        ST_WAIT:
          if (halt_now)
            state <= ST_IDLE;
          else if (pace_step)
          begin
            pace <= pace - 32'h1;
            if (pace == 32'h1)
              state <= ST_LOAD;
          end
        default:
          state <= ST_IDLE;
      endcase
    end
  end

endmodule

// ===== tb/mof_formatter_assertions.sv
/* Concurrent checks on the formatter's command and byte ports.
   Assumes it is bound to mof_formatter and sees only its ports. */
`timescale 1ns/1ns
module mof_chk
  import mof_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic cmd_valid,
  input wire mof_cmd_t cmd,
  input wire logic cmd_ready,
  input wire logic out_valid,
  input wire logic [7:0] out_data,
  input wire logic out_ready,
  input wire logic [2:0] fmt_code,
  input wire logic [15:0] rate_div,
  input wire logic busy
);
  // ************************************
  // Command decode and properties
  // ************************************
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  logic [15:0] held_p1;
  // Taken commands, split into legal and refused parameters.
  wire take = cmd_valid && cmd_ready;
  wire fs_ok = take && cmd.op == OP_FORMAT_SELECT && cmd.p1 < 16'h0006;
  wire fs_bad = take && cmd.op == OP_FORMAT_SELECT && cmd.p1 > 16'h0005;
  wire rd_ok = take && cmd.op == OP_RATE_DIVIDER && cmd.p1 != 16'h0000;
  wire rd_bad = take && cmd.op == OP_RATE_DIVIDER && cmd.p1 == 16'h0000;
  wire fq = take && cmd.op == OP_FORMAT_QUERY;
  // A copy of the parameter, so a stored value can be tied to its command.
  always_ff @(posedge sys_clk) held_p1 <= cmd.p1;
  chk_ack_zero: assert property (fs_ok |-> ##2 out_valid && out_data == CH_ZERO)
    else $error("format select not acknowledged with zero");
  chk_ack_error: assert property (fs_bad || rd_bad |-> ##2 out_valid && out_data == CH_ERROR)
    else $error("bad parameter not answered with error mark");
  chk_fmt_store: assert property (fs_ok |=> fmt_code == held_p1[2:0])
    else $error("format code not stored");
  chk_keep_old: assert property (fs_bad || rd_bad |=> $stable(fmt_code) && $stable(rate_div))
    else $error("refused command changed a setting");
  chk_div_store: assert property (rd_ok |=> rate_div == held_p1)
    else $error("rate divider not stored");
  chk_query_code: assert property (fq |-> ##2 out_valid && out_data == CH_ZERO + {5'h00, fmt_code})
    else $error("format query digit wrong");
  chk_byte_hold: assert property (out_valid && !out_ready |=> out_valid && $stable(out_data))
    else $error("output byte dropped before accept");
  chk_byte_gap: assert property (out_valid && out_ready |=> !out_valid)
    else $error("no bubble after accepted byte");
  chk_busy_block: assert property (busy && cmd.op != OP_OUTPUT_HALT |-> !cmd_ready)
    else $error("command taken while busy");
  chk_idle_ready: assert property (!busy |-> cmd_ready)
    else $error("idle formatter refused a command");
  // Main scenarios reached.
  cover property (fs_bad);
  cover property (fq);
  cover property (take && cmd.op == OP_OUTPUT_HALT && busy);
endmodule
bind mof_formatter mof_chk chk_u (.sys_clk(sys_clk), .rst(rst), .cmd_valid(cmd_valid), .cmd(cmd),
  .cmd_ready(cmd_ready), .out_valid(out_valid), .out_data(out_data), .out_ready(out_ready),
  .fmt_code(fmt_code), .rate_div(rate_div), .busy(busy));

// ===== tb/mof_host_model.sv
/* Host side of the byte link: a slow sink that stores every byte.
   Assumes out_valid and out_data follow a valid/ready handshake. */
`timescale 1ns/1ns
module mof_host_model
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic out_valid,
  input wire logic [7:0] out_data,
  output logic out_ready
);
  // ************************************
  // Receiver
  // ************************************
  logic [7:0] rx_q[$];
  // Random stalls; the live display is taken as off, so output is never held.
  always @(posedge sys_clk)
  begin
    if (!rst && out_valid && out_ready)
      rx_q.push_back(out_data);
    #1 out_ready <= ($urandom_range(2, 0) != 0);
  end
endmodule

// ===== tb/tb_top.sv
/* Self-checking bench for the measurement output formatter.
   Assumes the host model sink and the bound checker. */
`timescale 1ns/1ns
module tb_top
  import mof_pkg::*;
;
  // ************************************
  // Stimulus and checks
  // ************************************
  logic sys_clk = 1'b0, rst = 1'b1, cmd_valid = 1'b0, meas_tick = 1'b0;
  logic sign_reversal_input = 1'b0, aux_update = 1'b0;
  mof_cmd_t cmd = '0;
  mof_sample_t sample = '0;
  mof_aux_t aux = '0;
  logic [2:0] eng_decimals = 3'h0;
  logic [3:0] channel_select_cmd = 4'h3;
  logic [7:0] param_sep = 8'h3B, block_sep = 8'h0D, tick_cnt = 8'h00;
  wire cmd_ready, out_valid, out_ready, busy;
  wire [7:0] out_data;
  wire [5:0] sig_select;
  wire [2:0] fmt_code;
  wire [15:0] rate_div;
  int n_fail = 0, checks = 0, cyc = 0;
  logic [7:0] exp_q[$];
  mof_formatter #(.TENTH_CYCLES(10)) dut_u (.sys_clk(sys_clk), .rst(rst), .cmd_valid(cmd_valid),
    .cmd(cmd), .cmd_ready(cmd_ready), .meas_tick(meas_tick), .sample(sample),
    .sig_select(sig_select), .eng_decimals(eng_decimals), .channel_select_cmd(channel_select_cmd),
    .sign_reversal_input(sign_reversal_input), .aux_update(aux_update), .aux(aux),
    .param_sep(param_sep), .block_sep(block_sep), .out_valid(out_valid), .out_data(out_data),
    .out_ready(out_ready), .fmt_code(fmt_code), .rate_div(rate_div), .busy(busy));
  mof_host_model host_u (.sys_clk(sys_clk), .rst(rst), .out_valid(out_valid),
    .out_data(out_data), .out_ready(out_ready));
  always #10 sys_clk = ~sys_clk;
  // Short measurement cycle, one pulse every 16 clocks, to keep pacing quick.
  always @(posedge sys_clk)
  begin
    #1 tick_cnt <= tick_cnt + 8'h01;
    meas_tick <= (tick_cnt[3:0] == 4'h0);
  end
  // A hang is cut short well beyond the expected run length.
  always @(posedge sys_clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 20000)
    begin
      n_fail++;
      complete_run();
    end
  end
  task automatic cmp_byte(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("unexpected byte at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmp_reg(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("unexpected value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // Offer one command and hold it until the edge that takes it.
  task automatic send(input mof_op_t op, input logic [15:0] p1, input logic g,
    input logic [15:0] p2, input logic [15:0] p3);
    @(posedge sys_clk);
    #1;
    cmd_valid = 1'b1;
    cmd = '{op, p1, p2, g, p3};
    while (!cmd_ready)
    begin
      @(posedge sys_clk);
      #1;
    end
    @(posedge sys_clk);
    #1;
    cmd_valid = 1'b0;
  endtask
  function automatic void add_str(input string s);
    foreach (s[i]) exp_q.push_back(s[i]);
  endfunction
  // Expected binary bytes of one value: MSB first, reversed on odd codes.
  function automatic void add_bin(input logic [2:0] f, input logic [23:0] raw, input logic [7:0] st);
    logic [7:0] b[$];
    b = '{raw[23:16], raw[15:8]};
    if (f < 3'h4)
      b = '{raw[23:16], raw[15:8], raw[7:0], st};
    if (f[0])
      b.reverse();
    foreach (b[i]) exp_q.push_back(b[i]);
  endfunction
  // Wait for idle, then compare everything received with what was expected.
  task automatic check_rx();
    #1;
    while (busy !== 1'b0)
    begin
      @(posedge sys_clk);
      #1;
    end
    cmp_reg(16'(host_u.rx_q.size()), 16'(exp_q.size()));
    foreach (exp_q[i]) cmp_byte(host_u.rx_q[i], exp_q[i]);
    exp_q.delete();
    host_u.rx_q.delete();
  endtask
  task automatic complete_run();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  initial
  begin
    int n;
    logic [15:0] d;
    void'($urandom(32'h13b7_19f6));
    repeat (20) @(posedge sys_clk);
    #1 rst = 1'b0;
    cmp_reg(rate_div, RATE_DIV_RESET);
    for (int f = 7; f >= 0; f--)
    begin
      send(OP_FORMAT_SELECT, 16'(f), 1'b0, 16'h0000, 16'h0000);
      exp_q.push_back(f > 5 ? CH_ERROR : CH_ZERO);
      send(OP_FORMAT_QUERY, 16'h0000, 1'b0, 16'h0000, 16'h0000);
      exp_q.push_back(CH_ZERO + 8'(f > 5 ? 0 : f));
      check_rx();
    end
    d = 16'($urandom_range(9, 2));
    send(OP_RATE_DIVIDER, 16'h0000, 1'b0, 16'h0000, 16'h0000);
    send(OP_RATE_DIVIDER, d, 1'b0, 16'h0000, 16'h0000);
    add_str("?0");
    check_rx();
    cmp_reg(rate_div, d);
    // Peak signal with reversal on: raw bytes pass unchanged.
    sign_reversal_input = 1'b1;
    for (int f = 5; f >= 2; f--)
    begin
      sample.raw = 24'($urandom);
      sample.status = 8'($urandom);
      send(OP_FORMAT_SELECT, 16'(f), 1'b0, 16'h0000, 16'h0000);
      send(OP_VALUE_REQUEST, 16'h0003, 1'b1, 16'h0002, 16'h0001);
      add_str(f < 4 ? "0#18" : "0#14");
      add_bin(3'(f), sample.raw, sample.status);
      add_bin(3'(f), sample.raw, sample.status);
      check_rx();
      cmp_reg({10'h000, sig_select}, 16'h0003);
    end
    send(OP_VALUE_REQUEST, 16'h0011, 1'b1, 16'h0001, 16'h0000);
    send(OP_VALUE_REQUEST, 16'h0031, 1'b0, 16'h0000, 16'h0000);
    add_str("?#14");
    add_bin(3'h2, sample.raw, sample.status);
    check_rx();
    // Endless dynamic stream paced by the divider, halted once a few values are out.
    send(OP_VALUE_REQUEST, 16'h000D, 1'b1, 16'h0000, 16'h0000);
    while (host_u.rx_q.size() < 10) @(posedge sys_clk);
    send(OP_OUTPUT_HALT, 16'h0000, 1'b0, 16'h0000, 16'h0000);
    #1600;
    n = host_u.rx_q.size();
    cmp_byte(host_u.rx_q[0], CH_HASH);
    cmp_byte(host_u.rx_q[1], CH_ZERO);
    cmp_reg(16'(n % 4), 16'h0002);
    cmp_reg({15'h0000, busy}, 16'h0000);
    host_u.rx_q.delete();
    // Full ASCII: reversal turns a negative gross value positive.
    n = $urandom_range(999, 1);
    sample.eng = -n;
    eng_decimals = 3'h2;
    send(OP_FORMAT_SELECT, 16'h0000, 1'b0, 16'h0000, 16'h0000);
    send(OP_VALUE_REQUEST, 16'h0001, 1'b0, 16'h0000, 16'h0000);
    add_str($sformatf("0%0d.%02d%s3%s%0d", n / 100, n % 100, param_sep, param_sep, sample.status));
    exp_q.push_back(block_sep);
    check_rx();
    // Aux store: later changes stay unseen until the next update pulse.
    aux.volt = 32'sh0000_3039;
    aux.temp = AUX_LOW_DEG;
    aux.res_low = 1'b1;
    aux.exc_limit = 1'b1;
    aux_update = 1'b1;
    @(posedge sys_clk);
    #1 aux_update = 1'b0;
    aux.volt = 32'sh0000_0001;
    send(OP_AUX_VALUE_QUERY, 16'h0001, 1'b0, 16'h0000, 16'h0000);
    send(OP_AUX_VALUE_QUERY, 16'h0004, 1'b0, 16'h0000, 16'h0000);
    send(OP_AUX_VALUE_QUERY, 16'h0003, 1'b0, 16'h0000, 16'h0000);
    send(OP_AUX_VALUE_QUERY, 16'h0006, 1'b0, 16'h0000, 16'h0000);
    add_str("12.345999.9-100.00?");
    check_rx();
    complete_run();
  end
endmodule
